/* verilog/pmw_pkg.sv */
// Purpose: Shared constants and carriers for the power mode controller
// Assumes: Avalon-MM register map with 32-bit words, byte addressed
// Notes:   Offsets, control field positions and register reset values live here; status bits are placed in pmw_ctrl

// =====================================================================
// Package
package pmw_pkg;

  // Register byte offsets
  localparam logic [4:0] REG_CLKCTL = 5'h00;
  localparam logic [4:0] REG_OSC    = 5'h04;
  localparam logic [4:0] REG_STAT   = 5'h08;
  localparam logic [4:0] REG_WAKE   = 5'h0c;
  localparam logic [4:0] REG_WDT    = 5'h10;

  // Clock control field positions
  localparam int CK_SEL_LSB = 5;
  localparam int CK_HS_SRC  = 3;
  localparam int CK_LS_SRC  = 2;
  localparam int CK_HS_KEEP = 1;
  localparam int CK_LS_KEEP = 0;

  // Oscillator control field positions, stable flags read above them
  localparam int OS_RC_EN    = 0;
  localparam int OS_XT_EN    = 1;
  localparam int OS_LX_EN    = 2;
  localparam int OS_FREQ_LSB = 4;
  localparam int OS_FLAG_LSB = 8;

  // Reset values
  localparam logic [7:0] CLKCTL_RST = 8'h00;
  localparam logic [7:0] OSC_RST    = 8'h01;
  localparam logic [7:0] WAKE_RST   = 8'h00;
  localparam logic       WDT_EN_RST = 1'b1;

  localparam logic [2:0] SEL_SLOW = 3'h7;

  // Pins: [14:7] port A, [6] reset pin, [5] ls crystal clk,
  // [4] ls rc clk, [3:0] oscillator ready lines
  localparam int         PIN_W   = 15;
  localparam logic [14:0] PIN_RST = 15'h7fc0;

  // Cycle counts
  localparam logic [4:0]  OSC_SETTLE_CYC = 5'h10;
  localparam logic [19:0] WDT_LIMIT_DEF  = 20'h00100;

  typedef struct packed {
    logic       hs_run;
    logic       ls_run;
    logic       rc_lowspeed_osc_run;
    logic       sys_slow;
    logic [2:0] div;
  } pmw_clk_ctrl_type;

  typedef struct packed {
    logic full_reset;
    logic wdt_reset;
    logic irq_service;
    logic resume;
  } pmw_wake_evt_type;

endpackage : pmw_pkg

/* verilog/pmw_ctrl.sv */
// Purpose: Operating mode, halt and wake-up controller of a small MCU
// Assumes: mclk_i is the high-speed clock; low-speed clocks and ready
//          lines arrive on pins and are synchronised here
// Notes:   System clock is given as a tick enable for the core
//
// Summary of operation
// R01: Select code 111 moves the system clock to the low-speed clock.
// R02: Select codes 000 to 110 divide the high-speed clock by 1 to 64.
// R03: Slow mode uses the chosen low-speed oscillator once it is stable.
// R04: Software waits for the high-speed stable flag before fast mode.
// R05: Halt with both keep bits low enters sleep; only watchdog runs.
// R06: Halt with only low-speed keep set stops high-speed clock and CPU.
// R07: Halt with both keep bits set keeps both clocks, stops the CPU.
// R08: Halt with only high-speed keep set stops low-speed clock and CPU.
// R09: Entering any halt mode preserves memory, registers and ports.
// R10: Halt entry sets the power-down flag, clears the timeout flag.
// R11: Halt entry clears the watchdog; it counts on only if enabled.
// R12: Reset pin, port A fall, interrupt or watchdog overflow wake it.
// R13: Reset pin wake is a full reset; watchdog wake a watchdog reset.
// R14: Power-down flag cleared by power-up or watchdog clear, set by halt.
// R15: Watchdog timeout in halt sets timeout flag, resets only PC and SP.
// R16: Enabled port A pins wake on a falling edge; execution resumes.
// R17: Disabled interrupt or full stack: resume, interrupt stays pending.
// R18: Enabled interrupt with stack room gets normal interrupt response.
// R19: A request already set before halt cannot wake the device.
// R20: In sleep the low-speed RC clock runs while watchdog is enabled.
// R21: Enabling or retuning an oscillator clears then sets its flag.
// R22: After wake the CPU stays stopped until the system clock is stable.

module pmw_ctrl #(
  parameter int          NIRQ      = 4,
  parameter logic [19:0] WDT_LIMIT = pmw_pkg::WDT_LIMIT_DEF
) (
  input  wire logic                      mclk_i,
  input  wire logic                      rst_n_i,
  input  wire logic [4:0]                avs_address_i,
  input  wire logic                      avs_read_i,
  input  wire logic                      avs_write_i,
  input  wire logic [31:0]               avs_writedata_i,
  input  wire logic [3:0]                avs_byteenable_i,
  output logic      [31:0]               avs_readdata_o,
  output logic                           avs_waitrequest_o,
  input  wire logic                      halt_i,
  input  wire logic                      clr_wdt_i,
  input  wire logic [NIRQ-1:0]           irq_req_i,
  input  wire logic [NIRQ-1:0]           irq_en_i,
  input  wire logic                      stack_full_i,
  input  wire logic [7:0]                porta_i,
  input  wire logic                      external_reset_pin_n_i,
  input  wire logic                      crystal_ls_clk_i,
  input  wire logic                      rc_ls_clk_i,
  input  wire logic                      crystal_hs_ready_i,
  input  wire logic                      rc_hs_ready_i,
  input  wire logic                      crystal_ls_ready_i,
  input  wire logic                      rc_ls_ready_i,
  output pmw_pkg::pmw_clk_ctrl_type      clk_ctrl_o,
  output logic      [3:0]                osc_en_o,
  output logic                           sys_tick_o,
  output logic                           cpu_stop_o,
  output pmw_pkg::pmw_wake_evt_type      wake_o
);

  // ===================================================================
  // State encoding
  typedef enum logic [5:0] {
    ST_RUN       = 6'h01,
    ST_SLEEP     = 6'h02,
    ST_IDLE_LO   = 6'h04,
    ST_IDLE_BOTH = 6'h08,
    ST_IDLE_HI   = 6'h10,
    ST_WAKE      = 6'h20
  } pmw_state_type;

  function automatic logic [5:0] div_mask(input logic [2:0] sel);
    div_mask = 6'((7'h01 << sel) - 7'h01);
  endfunction : div_mask

  // ===================================================================
  // Pin synchronisers
  logic [14:0] sync1;
  logic [14:0] sync2;
  logic [14:0] sync3;
  logic [14:0] pin_lvl;
  logic [14:0] pin_lvl_d;
  wire  [14:0] pins_raw;
  wire  [14:0] next_pin_lvl;

  assign pins_raw = {porta_i, external_reset_pin_n_i, crystal_ls_clk_i,
                     rc_ls_clk_i, crystal_hs_ready_i, rc_hs_ready_i,
                     crystal_ls_ready_i, rc_ls_ready_i};
  // A change counts only when the last two stages agree
  assign next_pin_lvl = (sync2 & sync3) | (pin_lvl & (sync2 ^ sync3));

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sync1     <= pmw_pkg::PIN_RST;
      sync2     <= pmw_pkg::PIN_RST;
      sync3     <= pmw_pkg::PIN_RST;
      pin_lvl   <= pmw_pkg::PIN_RST;
      pin_lvl_d <= pmw_pkg::PIN_RST;
    end
    else
    begin
      sync1     <= pins_raw;
      sync2     <= sync1;
      sync3     <= sync2;
      pin_lvl   <= next_pin_lvl;
      pin_lvl_d <= pin_lvl;
    end
  end

  wire [7:0] porta_fall = pin_lvl_d[14:7] & ~pin_lvl[14:7];
  wire       ext_rst    = ~pin_lvl[6];
  wire       lx_tick    = pin_lvl[5] & ~pin_lvl_d[5];
  wire       rc_lowspeed_osc_tick  = pin_lvl[4] & ~pin_lvl_d[4];
  wire [3:0] osc_ready  = pin_lvl[3:0];

  // ===================================================================
  // Registers and bus slave
  pmw_state_type state;
  logic [7:0]    clkctl;
  logic [7:0]    oscreg;
  logic [7:0]    wake_en;
  logic          wdt_en;
  logic          powerdown_flag;
  logic          tof;
  logic          bus_ack;
  logic [2:0]    osc_flag;

  wire bus_req  = avs_read_i | avs_write_i;
  wire wr_ok    = avs_write_i & bus_ack & avs_byteenable_i[0];
  wire wr_ck    = wr_ok & (avs_address_i == pmw_pkg::REG_CLKCTL);
  wire wr_osc   = wr_ok & (avs_address_i == pmw_pkg::REG_OSC);
  wire wr_wake  = wr_ok & (avs_address_i == pmw_pkg::REG_WAKE);
  wire wr_wdt   = wr_ok & (avs_address_i == pmw_pkg::REG_WDT);
  wire [7:0] wd = avs_writedata_i[7:0];

  wire [2:0] sel     = clkctl[pmw_pkg::CK_SEL_LSB +: 3];
  wire       hs_src  = clkctl[pmw_pkg::CK_HS_SRC];
  wire       ls_src  = clkctl[pmw_pkg::CK_LS_SRC];
  wire       hs_keep = clkctl[pmw_pkg::CK_HS_KEEP];
  wire       ls_keep = clkctl[pmw_pkg::CK_LS_KEEP];
  wire [1:0] freq    = oscreg[pmw_pkg::OS_FREQ_LSB +: 2];

  // One wait state; a write lands on the edge where waitrequest is low
  assign avs_waitrequest_o = bus_req & ~bus_ack;

  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (avs_address_i)
      pmw_pkg::REG_CLKCTL: rd_mux = {24'h000000, clkctl & 8'hef};
      pmw_pkg::REG_OSC:    rd_mux = {21'h000000, osc_flag, 2'h0, freq,
                                     1'b0, oscreg[2:0]};
      pmw_pkg::REG_STAT:   rd_mux = {18'h00000, state, 6'h00, tof, powerdown_flag};
      pmw_pkg::REG_WAKE:   rd_mux = {24'h000000, wake_en};
      pmw_pkg::REG_WDT:    rd_mux = {31'h00000000, wdt_en};
      default:             rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      bus_ack        <= 1'b0;
      avs_readdata_o <= 32'h0000_0000;
    end
    else
    begin
      bus_ack        <= bus_req & ~bus_ack;
      avs_readdata_o <= rd_mux;
    end
  end

  // Full reset from the pin returns software settings to their defaults
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      clkctl  <= pmw_pkg::CLKCTL_RST;
      oscreg  <= pmw_pkg::OSC_RST;
      wake_en <= pmw_pkg::WAKE_RST;
      wdt_en  <= pmw_pkg::WDT_EN_RST;
    end
    else if (ext_rst)
    begin
      clkctl  <= pmw_pkg::CLKCTL_RST; // R13
      oscreg  <= pmw_pkg::OSC_RST;
      wake_en <= pmw_pkg::WAKE_RST;
      wdt_en  <= pmw_pkg::WDT_EN_RST;
    end
    else
    begin
      if (wr_ck)
        clkctl <= wd;
      if (wr_osc)
        oscreg <= wd & 8'h37;
      if (wr_wake)
        wake_en <= wd; // R16
      if (wr_wdt)
        wdt_en <= wd[0];
    end
  end

  // ===================================================================
  // Oscillator gating and stable flags
  wire hs_allowed = ~(state == ST_SLEEP || state == ST_IDLE_LO); // R05 R06
  wire ls_allowed = ~(state == ST_SLEEP || state == ST_IDLE_HI); // R05 R08
  wire rc_lowspeed_osc_run   = (ls_allowed & ~ls_src) | wdt_en;            // R20
  wire [2:0] osc_want = {oscreg[pmw_pkg::OS_LX_EN] & ls_allowed,
                         oscreg[pmw_pkg::OS_XT_EN] & hs_allowed,
                         oscreg[pmw_pkg::OS_RC_EN] & hs_allowed};
  wire freq_chg = wr_osc & (wd[pmw_pkg::OS_FREQ_LSB +: 2] != freq);
  wire [2:0] osc_rdy = {osc_ready[1], osc_ready[3], osc_ready[2]};
  logic [2:0] osc_want_d;

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      osc_want_d <= 3'h0;
    else
      osc_want_d <= osc_want;
  end

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_osc
      logic [4:0] settle;
      wire restart = (osc_want[gi] & ~osc_want_d[gi]) |
                     ((gi == 0) & freq_chg);
      always_ff @(posedge mclk_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
        begin
          settle       <= 5'h00;
          osc_flag[gi] <= 1'b0;
        end
        else if (restart || !osc_want[gi] || !osc_rdy[gi])
        begin
          settle       <= 5'h00; // R21
          osc_flag[gi] <= 1'b0;
        end
        else if (settle != pmw_pkg::OSC_SETTLE_CYC)
          settle <= settle + 5'h01;
        else
          osc_flag[gi] <= 1'b1; // R21
      end
    end
  endgenerate

  wire hs_stable = hs_src ? osc_flag[1] : osc_flag[0];
  wire ls_stable = ls_src ? osc_flag[2] : (rc_lowspeed_osc_run & osc_ready[0]);

  // ===================================================================
  // System clock source and divider
  logic       sys_slow;
  logic [5:0] div_cnt;

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sys_slow <= 1'b0;
      div_cnt  <= 6'h00;
    end
    else
    begin
      div_cnt <= div_cnt + 6'h01;
      if (sel == pmw_pkg::SEL_SLOW && ls_stable)
        sys_slow <= 1'b1; // R01 R03
      else if (sel != pmw_pkg::SEL_SLOW && hs_stable)
        sys_slow <= 1'b0; // R02
    end
  end

  wire slow_tick = ls_src ? lx_tick : rc_lowspeed_osc_tick;
  wire fast_tick = (div_cnt & div_mask(sel)) == div_mask(sel); // R02
  wire halted    = state != ST_RUN;

  // ===================================================================
  // Watchdog counter
  logic [19:0] wdt_cnt;
  wire halt_go = halt_i & (state == ST_RUN);
  wire wdt_ovf = wdt_en & rc_lowspeed_osc_tick & (wdt_cnt == WDT_LIMIT - 20'h1);

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      wdt_cnt <= 20'h00000;
    else if (halt_go || clr_wdt_i || ext_rst || wdt_ovf)
      wdt_cnt <= 20'h00000; // R11
    else if (wdt_en && rc_lowspeed_osc_tick)
      wdt_cnt <= wdt_cnt + 20'h1; // R11
  end

  // ===================================================================
  // Mode sequencer
  logic [NIRQ-1:0] irq_held;
  logic            woke_irq;
  pmw_state_type   next_state;

  wire [NIRQ-1:0] irq_new  = irq_req_i & ~irq_held; // R19
  wire            port_wk  = |(porta_fall & wake_en); // R16
  wire            wake_req = port_wk | (|irq_new) | wdt_ovf; // R12
  wire            clk_ok   = sys_slow ? ls_stable : hs_stable;
  wire            irq_take = woke_irq & |(irq_req_i & irq_en_i) &
                             ~stack_full_i;

  always_comb
  begin
    next_state = state;
    case (state)
      ST_RUN:
        if (halt_i)
        begin
          case ({hs_keep, ls_keep})
            2'b00:   next_state = ST_SLEEP;     // R05
            2'b01:   next_state = ST_IDLE_LO;   // R06
            2'b11:   next_state = ST_IDLE_BOTH; // R07
            default: next_state = ST_IDLE_HI;   // R08
          endcase
        end
      ST_SLEEP, ST_IDLE_LO, ST_IDLE_BOTH, ST_IDLE_HI:
        if (wake_req)
          next_state = ST_WAKE; // R12
      ST_WAKE:
        if (clk_ok)
          next_state = ST_RUN; // R22
      default:
        next_state = ST_RUN;
    endcase
    if (ext_rst)
      next_state = ST_RUN; // R13
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state    <= ST_RUN;
      irq_held <= '0;
      woke_irq <= 1'b0;
      powerdown_flag      <= 1'b0;
      tof      <= 1'b0;
      wake_o   <= '0;
    end
    else
    begin
      state              <= next_state;
      wake_o.full_reset  <= ext_rst; // R13
      wake_o.wdt_reset   <= wdt_ovf & ~ext_rst; // R13 R15
      wake_o.irq_service <= 1'b0;
      wake_o.resume      <= 1'b0;
      if (halt_go)
        irq_held <= irq_req_i; // R19
      if (halted && state != ST_WAKE && wake_req)
        woke_irq <= (|irq_new) & ~port_wk & ~wdt_ovf;
      if (state == ST_WAKE && clk_ok && !ext_rst)
      begin
        wake_o.irq_service <= irq_take;  // R18
        wake_o.resume      <= ~irq_take; // R16 R17
        woke_irq           <= 1'b0;
      end
      // Halt sets, watchdog clear clears; the set wins
      if (halt_go)
        powerdown_flag <= 1'b1; // R10 R14
      else if (clr_wdt_i)
        powerdown_flag <= 1'b0; // R14
      if (wdt_ovf)
        tof <= 1'b1; // R15
      else if (halt_go)
        tof <= 1'b0; // R10
    end
  end

  // ===================================================================
  // Outputs: only clocks are gated, so state is held untouched in halt
  assign cpu_stop_o          = halted; // R09
  assign sys_tick_o          = ~halted & (sys_slow ? slow_tick : fast_tick);
  assign clk_ctrl_o.hs_run   = hs_allowed;
  assign clk_ctrl_o.ls_run   = ls_allowed;
  assign clk_ctrl_o.rc_lowspeed_osc_run = rc_lowspeed_osc_run;
  assign clk_ctrl_o.sys_slow = sys_slow;
  assign clk_ctrl_o.div      = sel;
  assign osc_en_o            = {rc_lowspeed_osc_run, osc_want[2], osc_want[1],
                                osc_want[0]};

endmodule : pmw_ctrl

/* tb/pmw_ctrl_properties.sv */
// Purpose: Port properties of the power mode controller
// Assumes: One clock domain, reset active low
// Notes:   Bound into every pmw_ctrl instance
module pmw_ctrl_properties (
  input wire logic                      mclk_i,
  input wire logic                      rst_n_i,
  input wire logic                      avs_read_i,
  input wire logic                      avs_write_i,
  input wire logic                      avs_waitrequest_o,
  input wire logic                      halt_i,
  input wire logic                      external_reset_pin_n_i,
  input wire pmw_pkg::pmw_clk_ctrl_type clk_ctrl_o,
  input wire logic                      sys_tick_o,
  input wire logic                      cpu_stop_o,
  input wire pmw_pkg::pmw_wake_evt_type wake_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);

  // ==============================
  // Assertions
  a_bus_one_wait:
    assert property ((avs_read_i | avs_write_i) && !$past(avs_read_i |
      avs_write_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
    else $error("bus wait state wrong");
  a_halt_stops_cpu:
    assert property (halt_i && !cpu_stop_o && !wake_o.full_reset |=>
      cpu_stop_o) else $error("halt did not stop cpu");
  a_no_tick_stopped:
    assert property (cpu_stop_o |-> !sys_tick_o)
    else $error("tick while cpu stopped");
  a_slow_on_code:
    assert property ($rose(clk_ctrl_o.sys_slow) |->
      clk_ctrl_o.div == 3'h7) else $error("slow mode without code");
  a_fast_full_rate:
    assert property ((!cpu_stop_o && !clk_ctrl_o.sys_slow &&
      clk_ctrl_o.div == 3'h0)[*3] |-> sys_tick_o)
    else $error("undivided clock missed a tick");
  a_pin_full_reset:
    assert property ($fell(external_reset_pin_n_i) |->
      ##[2:6] wake_o.full_reset) else $error("no full reset");
  a_full_reset_runs:
    assert property (wake_o.full_reset |-> ##1 !cpu_stop_o)
    else $error("cpu stopped after full reset");
  a_resume_pulse:
    assert property (wake_o.resume || wake_o.irq_service |->
      !cpu_stop_o ##1 !(wake_o.resume || wake_o.irq_service))
    else $error("resume pulse wrong");
  a_wake_waits_osc:
    assert property ($rose(clk_ctrl_o.hs_run) && cpu_stop_o &&
      !clk_ctrl_o.sys_slow |=> cpu_stop_o)
    else $error("cpu released before oscillator restart");
  a_wdt_pulse:
    assert property (wake_o.wdt_reset |=> !wake_o.wdt_reset)
    else $error("watchdog reset not a pulse");

  c_halt: cover property (halt_i && !cpu_stop_o);
  c_resume: cover property (wake_o.resume);
  c_irq: cover property (wake_o.irq_service);
  c_wdt: cover property (wake_o.wdt_reset);
endmodule : pmw_ctrl_properties

bind pmw_ctrl pmw_ctrl_properties u_props (.*);

/* tb/pmw_cpu_model.sv */
// Purpose: CPU core and oscillator model beside the controller
// Assumes: Oscillators settle four cycles after their enable rises
// Notes:   Low-speed clocks stand low while their oscillator is off
module pmw_cpu_model (
  input  wire logic       mclk_i,
  input  wire logic       rst_n_i,
  input  wire logic [3:0] osc_en_i,
  input  wire logic       halt_req_i,
  input  wire logic       cpu_stop_i,
  output logic            halt_o,
  output logic [3:0]      ready_o,
  output logic [1:0]      lsclk_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] age [4];
  logic [2:0] ph;

  // ==============================
  // Oscillators
  always_comb
    for (int k = 0; k < 4; k++)
      ready_o[k] = &age[k];
  assign lsclk_o = {2{ph[2]}} & osc_en_i[3:2];

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      halt_o <= 1'b0;
      ph     <= 3'h0;
      age    <= '{default: 4'h0};
    end
    else
    begin
      // A stopped core cannot execute a second halt
      halt_o <= halt_req_i & ~cpu_stop_i;
      ph     <= ph + 3'h1;
      for (int k = 0; k < 4; k++)
        age[k] <= {age[k][2:0], osc_en_i[k]};
    end
  end
endmodule : pmw_cpu_model

/* tb/tb_pmw_ctrl.sv */
// Purpose: Self-checking bench of the power mode controller
// Assumes: 40 MHz clock; core and oscillators come from the model
// Notes:   Watchdog limit cut to 4 ticks to keep the run short
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin failures++; \
  $display("unexpected at %0t: got %h exp %h", $time, g, e); end end

module tb_pmw_ctrl;
  timeunit 1ns;
  timeprecision 100ps;
  logic        mclk_i, rst_n_i, avs_read_i, avs_write_i, halt_req;
  logic        clr_wdt_i, stack_full_i, external_reset_pin_n_i, halt_i;
  logic        avs_waitrequest_o, sys_tick_o, cpu_stop_o;
  logic [4:0]  avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, d;
  logic [3:0]  avs_byteenable_i, irq_req_i, irq_en_i, osc_en_o, rdy;
  logic [7:0]  porta_i;
  logic [1:0]  lsclk;
  int          failures, n_tests, cnt;
  pmw_pkg::pmw_clk_ctrl_type clk_ctrl_o;
  pmw_pkg::pmw_wake_evt_type wake_o, w;
  localparam logic [5:0] ST [4] = '{6'h02, 6'h04, 6'h10, 6'h08};

  pmw_ctrl #(.WDT_LIMIT(20'h00004)) uut (.*,
    .rc_hs_ready_i(rdy[0]), .crystal_hs_ready_i(rdy[1]),
    .crystal_ls_ready_i(rdy[2]), .rc_ls_ready_i(rdy[3]),
    .crystal_ls_clk_i(lsclk[0]), .rc_ls_clk_i(lsclk[1]));
  pmw_cpu_model cpu (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .osc_en_i(osc_en_o), .halt_req_i(halt_req),
    .cpu_stop_i(cpu_stop_o), .halt_o(halt_i), .ready_o(rdy),
    .lsclk_o(lsclk));

  // ==============================
  // Shared tasks
  task automatic report_and_stop;
    $display("comparisons %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop

  task automatic fail_out;
    failures++;
    report_and_stop();
  endtask : fail_out

  task automatic bus(input logic we, input logic [4:0] a,
                     input logic [31:0] wd);
    int n;
    @(posedge mclk_i);
    avs_address_i   <= a;
    avs_writedata_i <= wd;
    avs_write_i     <= we;
    avs_read_i      <= !we;
    n = 0;
    do
    begin
      @(posedge mclk_i);
      n++;
    end
    while (avs_waitrequest_o !== 1'b0 && n < 20);
    d = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
    if (n >= 20) fail_out();
  endtask : bus

  // Selector 0 watches cpu stop, 1 slow mode, 2 any wake event
  task automatic await(input int s, input logic v);
    int n;
    for (n = 0; n < 500; n++)
    begin
      @(posedge mclk_i);
      if ((s == 0 ? cpu_stop_o : s == 1 ? clk_ctrl_o.sys_slow
           : |wake_o) === v) break;
    end
    w = wake_o;
    cnt = n;
    if (n == 500) fail_out();
  endtask : await

  task automatic count(input int n);
    cnt = 0;
    repeat (n)
    begin
      @(posedge mclk_i);
      cnt += int'(sys_tick_o);
    end
  endtask : count

  task automatic do_halt;
    halt_req <= 1'b1;
    @(posedge mclk_i);
    halt_req <= 1'b0;
    await(0, 1'b1);
  endtask : do_halt

  // ==============================
  // Scenarios
  task automatic t_regs;
    bus(0, pmw_pkg::REG_CLKCTL, '0);
    `CHK(d, 32'h0)
    bus(0, pmw_pkg::REG_STAT, '0);
    `CHK(d, 32'h100)
    bus(1, 5'h14, 32'hff);
    bus(0, 5'h14, '0);
    `CHK(d, 32'h0)
    bus(1, pmw_pkg::REG_WDT, '0);
    bus(1, pmw_pkg::REG_OSC, 32'h3);
    bus(0, pmw_pkg::REG_OSC, '0);
    `CHK(d[9], 1'b0)
    repeat (40) @(posedge mclk_i);
    bus(0, pmw_pkg::REG_OSC, '0);
    `CHK(d[9], 1'b1)
  endtask : t_regs

  task automatic t_div;
    for (int k = 0; k < 7; k++)
    begin
      bus(1, pmw_pkg::REG_CLKCTL, 32'(k << 5));
      count(8);
      count(128);
      `CHK(cnt, 128 >> k)
    end
  endtask : t_div

  task automatic t_slow;
    bus(1, pmw_pkg::REG_CLKCTL, 32'he0);
    await(1, 1'b1);
    `CHK(clk_ctrl_o.div, pmw_pkg::SEL_SLOW)
    count(64);
    `CHK(cnt, 8)
    bus(1, pmw_pkg::REG_CLKCTL, 32'h0);
    bus(0, pmw_pkg::REG_OSC, '0);
    `CHK(d[8], 1'b1)
    await(1, 1'b0);
  endtask : t_slow

  task automatic t_halt;
    for (int k = 0; k < 4; k++)
    begin
      bus(1, pmw_pkg::REG_WAKE, 32'h1);
      bus(1, pmw_pkg::REG_CLKCTL, 32'(k));
      do_halt();
      bus(0, pmw_pkg::REG_STAT, '0);
      `CHK(d, {18'h0, ST[k], 8'h01})
      `CHK({clk_ctrl_o.hs_run, clk_ctrl_o.ls_run}, 2'(k))
      porta_i <= 8'hfe;
      await(2, 1'b1);
      `CHK(w, 4'b0001)
      porta_i <= 8'hff;
      bus(0, pmw_pkg::REG_CLKCTL, '0);
      `CHK(d, 32'(k))
      bus(0, pmw_pkg::REG_STAT, '0);
      `CHK(d, 32'h101)
      clr_wdt_i <= 1'b1;
      @(posedge mclk_i);
      clr_wdt_i <= 1'b0;
      bus(0, pmw_pkg::REG_STAT, '0);
      `CHK(d, 32'h100)
    end
  endtask : t_halt

  task automatic t_irq;
    bus(1, pmw_pkg::REG_CLKCTL, 32'h3);
    for (int k = 0; k < 3; k++)
    begin
      irq_en_i     <= (k == 1) ? 4'h0 : 4'h6;
      stack_full_i <= (k == 2);
      irq_req_i    <= 4'h2;
      do_halt();
      repeat (40) @(posedge mclk_i);
      `CHK(cpu_stop_o, 1'b1)
      irq_req_i <= 4'h6;
      await(2, 1'b1);
      `CHK(w, (k == 0) ? 4'b0010 : 4'b0001)
      irq_req_i <= 4'h0;
    end
  endtask : t_irq

  task automatic t_wdt;
    bus(1, pmw_pkg::REG_CLKCTL, 32'h0);
    bus(1, pmw_pkg::REG_WDT, 32'h1);
    repeat (16) @(posedge mclk_i);
    do_halt();
    `CHK(osc_en_o[3], 1'b1)
    `CHK(osc_en_o, 4'h8)
    `CHK(clk_ctrl_o.rc_lowspeed_osc_run, 1'b1)
    await(2, 1'b1);
    `CHK(w, 4'b0100)
    `CHK(cnt >= 22, 1'b1)
    `CHK(cnt <= 31, 1'b1)
    await(0, 1'b0);
    bus(1, pmw_pkg::REG_WDT, 32'h0);
    bus(0, pmw_pkg::REG_STAT, '0);
    `CHK(d, 32'h103)
  endtask : t_wdt

  task automatic t_pin;
    bus(1, pmw_pkg::REG_CLKCTL, 32'h3);
    do_halt();
    bus(0, pmw_pkg::REG_STAT, '0);
    `CHK(d, 32'h801)
    external_reset_pin_n_i <= 1'b0;
    repeat (8) @(posedge mclk_i);
    `CHK(wake_o.full_reset, 1'b1)
    `CHK(cpu_stop_o, 1'b0)
    external_reset_pin_n_i <= 1'b1;
    repeat (8) @(posedge mclk_i);
    bus(0, pmw_pkg::REG_CLKCTL, '0);
    `CHK(d, 32'h0)
  endtask : t_pin

  // ==============================
  // Clock and main sequence
  initial
  begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end

  initial
  begin
    {rst_n_i, avs_read_i, avs_write_i, halt_req, clr_wdt_i} = '0;
    {stack_full_i, irq_req_i, irq_en_i, avs_address_i} = '0;
    avs_writedata_i = '0;
    avs_byteenable_i = 4'hf;
    porta_i = 8'hff;
    external_reset_pin_n_i = 1'b1;
    failures = 0;
    n_tests = 0;
    repeat (12) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    // Short settle: the enabled watchdog must not overflow before t_regs
    repeat (4) @(posedge mclk_i);
    t_regs();
    t_div();
    t_slow();
    t_halt();
    t_irq();
    t_wdt();
    t_pin();
    report_and_stop();
  end
endmodule : tb_pmw_ctrl
